// >>> rtl/irc_pkg.sv
// Constants and carrier types shared by the system-control block.
`default_nettype none
package irc_pkg;
  localparam logic [7:0]  CLKDIV_ADDR     = 8'hE5;   // Logic clock divider control.
  localparam int          DIVSEL_LSB      = 1;
  localparam int          DIVSEL_W        = 3;
  localparam int          FULLSPD_BIT     = 0;
  localparam logic [7:0]  CLKDIV_RESET    = 8'h00;
  localparam logic [2:0]  DIV_STOP        = 3'h7;
  localparam logic [2:0]  DIV_FASTEST     = 3'h0;
  localparam logic [15:0] RESET_VECTOR    = 16'h0000;
  localparam int          PHASES_PER_INSN = 4;
  localparam int          CALL_INSN       = 4;       // Instruction cycles of the long call.
  localparam int          MIN_LATENCY     = 5;
  localparam int          MAX_LATENCY     = 13;
  localparam int          CLK_MHZ         = 100;
  localparam int          POR_MIN_MS      = 10;
  localparam int          POR_CYCLES      = POR_MIN_MS * CLK_MHZ * 1000;
  localparam int          EXT_RST_CYCLES  = 8;
  localparam int          CNT_W           = 20;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } irc_sfr_t;

  typedef struct packed {
    logic [2:0] sel;
    logic       full_spd;
  } irc_div_cfg_t;
endpackage : irc_pkg
`default_nettype wire

// >>> rtl/irc_clkdiv.sv
// Glitch-free power-of-two divider that produces the logic clock.
`timescale 1ns/10ps
`default_nettype none
module irc_clkdiv (
  input  wire logic       clk_in,   // External clock.
  input  wire logic       rst_in,   // Synchronous reset, active high.
  input  wire logic [2:0] sel_in,   // Divider select code.
  input  wire logic       fast_in,  // Force maximum speed.
  output logic            clk_out,  // Divided logic clock.
  output logic            tick_out  // One-cycle pulse at each logic clock rising edge.
);
  import irc_pkg::*;

  logic [2:0] eff_q;
  logic [6:0] cnt_q;
  logic [2:0] req;

  function automatic logic [6:0] half_last(input logic [2:0] s);
    half_last = 7'((8'h01 << s) - 8'h01);
  endfunction

  assign req = fast_in ? DIV_FASTEST : sel_in;

  // The setting is taken only as a high phase ends or while stopped, so no high or low phase is ever shortened.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      eff_q    <= DIV_FASTEST;
      cnt_q    <= 7'h00;
      clk_out  <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (eff_q == DIV_STOP) begin
        clk_out <= 1'b0;
        eff_q   <= req;
        cnt_q   <= 7'h00;
      end else if (cnt_q == half_last(eff_q)) begin
        cnt_q    <= 7'h00;
        clk_out  <= ~clk_out;
        tick_out <= ~clk_out;
        if (clk_out) begin
          eff_q <= req;
        end
      end else begin
        cnt_q <= 7'(cnt_q + 7'h01);
      end
    end
  end
endmodule // irc_clkdiv
`default_nettype wire

// >>> rtl/irc_sysctl.sv
// Interrupt sampling, response timing, reset control and logic clock divider.
// Summary of operation
// - External interrupt pins are sampled once per instruction cycle, end of phase four.
// - Inputs a and c are edge only; a active low, c active high.
// - With type select 0, input b is level mode; low sample sets flag.
// - With type select 1, b flag sets on high sample then low sample.
// - Level requests are not latched; source holds them until serviced.
// - Timers and serial ports request interrupts through their own flag bits.
// - Fastest response is five instruction cycles: detect plus four call cycles.
// - Worst response is thirteen cycles: detect, return, multiply or divide, call.
// - After a return, one main-program instruction runs before any new entry.
// - Power-on and external resets both hold the core while either is active.
// - Either reset loads register reset values; internal RAM is untouched.
// - On reset release the core fetches from address zero.
// - Internal power-on reset stays low for at least ten milliseconds.
// - External reset needs eight clocks low; shorter pulses are ignored.
// - Divider select field, bits three to one, sets the logic clock rate.
// - Codes zero to six divide by 2 to 128; code seven stops.
// - Full-speed bit set: qualifying interrupt forces maximum speed until cleared.
// - Qualifying interrupts: converter, peripheral serial, and the three external inputs.
`timescale 1ns/10ps
`default_nettype none
module irc_sysctl #(
  parameter int POR_HOLD = irc_pkg::POR_CYCLES,  // Power-on stretch in clock cycles.
  parameter int N_PERIPH = 4                     // Timer and serial flag count.
) (
  input  wire logic                MCLK_IN,          // External clock, 100 MHz.
  input  wire logic                RST_IN,           // Synchronous reset, active high.
  input  wire logic                POR_N_IN,         // Power-on/brown-out reset, active low.
  input  wire logic                EXT_RST_N_IN,     // External reset pin, active low.
  input  wire logic                EXT_IRQ_A_N_IN,   // External interrupt a pin, active low.
  input  wire logic                EXT_IRQ_B_N_IN,   // External interrupt b pin, active low.
  input  wire logic                EXT_IRQ_C_IN,     // External interrupt c pin, active high.
  input  wire logic                PERIPH_IRQ_N_IN,  // Peripheral serial interrupt pin, active low.
  input  wire logic                ADC_IRQ_IN,       // Converter interrupt flag.
  input  wire logic [N_PERIPH-1:0] PERIPH_FLAGS_IN,  // Timer and serial flag bits.
  input  wire logic                IRQ_B_TYPE_SEL_IN,// Type select for input b, 1 is edge.
  input  wire logic                IRQ_A_CLR_IN,     // Software clear of flag a.
  input  wire logic                IRQ_B_CLR_IN,     // Software clear of flag b.
  input  wire logic                IRQ_C_CLR_IN,     // Software clear of flag c.
  input  wire logic                CORE_BOUNDARY_IN, // Core may start a call now.
  input  wire logic                RETURN_IN,        // Return from service routine completes.
  input  wire logic                INSN_DONE_IN,     // Main-program instruction completes.
  input  wire irc_pkg::irc_sfr_t   SFR_IN,           // Register port from the core.
  output logic [7:0]               SFR_RDATA_OUT,    // Register read data.
  output logic                     IRQ_A_FLAG_OUT,   // Flag a.
  output logic                     IRQ_B_FLAG_OUT,   // Flag b.
  output logic                     IRQ_C_FLAG_OUT,   // Flag c.
  output logic                     ISR_ENTER_OUT,    // Pulse: enter service routine.
  output logic                     CORE_RST_OUT,     // Core and register reset, active high.
  output logic [15:0]              FETCH_ADDR_OUT,   // Restart address.
  output logic                     LOGIC_CLK_OUT,    // Divided logic clock.
  output logic                     LOGIC_TICK_OUT    // Pulse at each logic clock rising edge.
);
  import irc_pkg::*;

  typedef enum logic [2:0] {
    SQ_IDLE = 3'b001,
    SQ_CALL = 3'b010,
    SQ_ISR  = 3'b100
  } irc_seq_t;

  logic [5:0]       meta_q;
  logic [5:0]       sync_q;
  logic             por_n_s;
  logic             ext_rst_n_s;
  logic             a_n_s;
  logic             b_n_s;
  logic             c_s;
  logic             periph_n_s;
  logic [CNT_W-1:0] por_cnt_q;
  logic             por_busy_q;
  logic [3:0]       rst_cnt_q;
  logic             ext_rst_q;
  logic             any_rst;
  logic             local_rst;
  irc_div_cfg_t     cfg_q;
  logic             div_clk;
  logic             div_tick;
  logic             fast_req;
  logic [1:0]       phase_q;
  logic             sample;
  logic             last_a_q;
  logic             last_b_q;
  logic             last_c_q;
  logic             flag_a_q;
  logic             flag_b_q;
  logic             flag_c_q;
  logic             pending;
  irc_seq_t         seq_q;
  logic [2:0]       call_cnt_q;
  logic             block_q;

  assign {por_n_s, ext_rst_n_s, a_n_s, b_n_s, c_s, periph_n_s} = sync_q;

  // Pins cross in through two flops; only the second stage is read.
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      meta_q <= 6'h3D;
      sync_q <= 6'h3D;
    end else begin
      meta_q <= {POR_N_IN, EXT_RST_N_IN, EXT_IRQ_A_N_IN, EXT_IRQ_B_N_IN, EXT_IRQ_C_IN, PERIPH_IRQ_N_IN};
      sync_q <= meta_q;
    end
  end

  // Power-on stretch restarts whenever the power monitor drops its line.
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || !por_n_s) begin
      por_cnt_q  <= '0;
      por_busy_q <= 1'b1;
    end else if (por_busy_q) begin
      por_cnt_q  <= CNT_W'(por_cnt_q + 1'b1);
      por_busy_q <= (int'(por_cnt_q) < POR_HOLD - 1);
    end
  end

  // A low pulse counts up; reset asserts only once it has lasted the minimum width.
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN || ext_rst_n_s) begin
      rst_cnt_q <= 4'h0;
      ext_rst_q <= 1'b0;
    end else if (int'(rst_cnt_q) < EXT_RST_CYCLES - 1) begin
      rst_cnt_q <= 4'(rst_cnt_q + 4'h1);
    end else begin
      ext_rst_q <= 1'b1;
    end
  end

  assign any_rst   = por_busy_q | ext_rst_q;
  assign local_rst = RST_IN | CORE_RST_OUT;

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      CORE_RST_OUT   <= 1'b1;
      FETCH_ADDR_OUT <= RESET_VECTOR;
    end else begin
      CORE_RST_OUT   <= any_rst;
      FETCH_ADDR_OUT <= RESET_VECTOR;
    end
  end

  // Register port. Internal RAM has no path here, so reset leaves it alone.
  always_ff @(posedge MCLK_IN) begin
    if (local_rst) begin
      cfg_q <= irc_div_cfg_t'(CLKDIV_RESET[DIVSEL_W:0]);
    end else if (SFR_IN.wr && SFR_IN.addr == CLKDIV_ADDR) begin
      cfg_q.sel      <= SFR_IN.wdata[DIVSEL_LSB +: DIVSEL_W];
      cfg_q.full_spd <= SFR_IN.wdata[FULLSPD_BIT];
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      SFR_RDATA_OUT <= 8'h00;
    end else if (SFR_IN.rd && SFR_IN.addr == CLKDIV_ADDR) begin
      SFR_RDATA_OUT <= {4'h0, cfg_q.sel, cfg_q.full_spd};
    end else begin
      SFR_RDATA_OUT <= 8'h00;
    end
  end

  assign fast_req = cfg_q.full_spd &
                    (ADC_IRQ_IN | ~periph_n_s | flag_a_q | flag_b_q | flag_c_q);

  irc_clkdiv u_div (
    .clk_in   (MCLK_IN),
    .rst_in   (local_rst),
    .sel_in   (cfg_q.sel),
    .fast_in  (fast_req),
    .clk_out  (div_clk),
    .tick_out (div_tick)
  );

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      LOGIC_CLK_OUT  <= 1'b0;
      LOGIC_TICK_OUT <= 1'b0;
    end else begin
      LOGIC_CLK_OUT  <= div_clk;
      LOGIC_TICK_OUT <= div_tick;
    end
  end

  // Four logic clock phases make one instruction cycle.
  always_ff @(posedge MCLK_IN) begin
    if (local_rst) begin
      phase_q <= 2'h0;
    end else if (div_tick) begin
      phase_q <= 2'(phase_q + 2'h1);
    end
  end

  assign sample = div_tick && (int'(phase_q) == PHASES_PER_INSN - 1);

  always_ff @(posedge MCLK_IN) begin
    if (local_rst) begin
      last_a_q <= 1'b1;
      last_b_q <= 1'b1;
      last_c_q <= 1'b0;
    end else if (sample) begin
      last_a_q <= a_n_s;
      last_b_q <= b_n_s;
      last_c_q <= c_s;
    end
  end

  // Edge capture needs a high and a low sample; short pulses can be missed.
  always_ff @(posedge MCLK_IN) begin
    if (local_rst) begin
      flag_a_q <= 1'b0;
    end else if (sample && last_a_q && !a_n_s) begin
      flag_a_q <= 1'b1;
    end else if (IRQ_A_CLR_IN) begin
      flag_a_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (local_rst) begin
      flag_c_q <= 1'b0;
    end else if (sample && !last_c_q && c_s) begin
      flag_c_q <= 1'b1;
    end else if (IRQ_C_CLR_IN) begin
      flag_c_q <= 1'b0;
    end
  end

  // In level mode the flag follows every sample, so a released request vanishes.
  always_ff @(posedge MCLK_IN) begin
    if (local_rst) begin
      flag_b_q <= 1'b0;
    end else if (sample && !IRQ_B_TYPE_SEL_IN) begin
      flag_b_q <= !b_n_s;
    end else if (sample && last_b_q && !b_n_s) begin
      flag_b_q <= 1'b1;
    end else if (IRQ_B_CLR_IN) begin
      flag_b_q <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      IRQ_A_FLAG_OUT <= 1'b0;
      IRQ_B_FLAG_OUT <= 1'b0;
      IRQ_C_FLAG_OUT <= 1'b0;
    end else begin
      IRQ_A_FLAG_OUT <= flag_a_q;
      IRQ_B_FLAG_OUT <= flag_b_q;
      IRQ_C_FLAG_OUT <= flag_c_q;
    end
  end

  assign pending = flag_a_q | flag_b_q | flag_c_q | ADC_IRQ_IN | ~periph_n_s | (|PERIPH_FLAGS_IN);

  // A completed return blocks entry until one main-program instruction finishes.
  always_ff @(posedge MCLK_IN) begin
    if (local_rst) begin
      block_q <= 1'b0;
    end else if (seq_q == SQ_ISR && RETURN_IN) begin
      block_q <= 1'b1;
    end else if (INSN_DONE_IN) begin
      block_q <= 1'b0;
    end
  end

  // Detection takes one instruction cycle, then the call runs for four more.
  // Extra delay comes only from the core holding off the boundary, from a service routine still running, or from the block after a return.
  always_ff @(posedge MCLK_IN) begin
    if (local_rst) begin
      seq_q         <= SQ_IDLE;
      call_cnt_q    <= 3'h0;
      ISR_ENTER_OUT <= 1'b0;
    end else begin
      ISR_ENTER_OUT <= 1'b0;
      unique case (seq_q)
        SQ_IDLE: begin
          if (sample && pending && !block_q && CORE_BOUNDARY_IN) begin
            seq_q      <= SQ_CALL;
            call_cnt_q <= 3'h0;
          end
        end
        SQ_CALL: begin
          if (sample) begin
            call_cnt_q <= 3'(call_cnt_q + 3'h1);
            if (int'(call_cnt_q) == CALL_INSN - 1) begin
              seq_q         <= SQ_ISR;
              ISR_ENTER_OUT <= 1'b1;
            end
          end
        end
        SQ_ISR: begin
          if (RETURN_IN) begin
            seq_q <= SQ_IDLE;
          end
        end
        default: begin
          seq_q <= SQ_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  property p_sample_phase;
    sample |=> (!sample)[*7];
  endproperty
  a_sample_phase: assert property (p_sample_phase) else $error("Sample off phase four.");

  property p_edge_a;
    sample && last_a_q && !a_n_s && !local_rst |=> flag_a_q ##1 IRQ_A_FLAG_OUT;
  endproperty
  a_edge_a: assert property (p_edge_a) else $error("Falling edge on a not flagged.");

  property p_level_b;
    sample && !IRQ_B_TYPE_SEL_IN && !local_rst |=> flag_b_q == !$past(b_n_s);
  endproperty
  a_level_b: assert property (p_level_b) else $error("Level flag b does not follow pin.");

  property p_edge_b_only;
    sample && IRQ_B_TYPE_SEL_IN && !flag_b_q && !(last_b_q && !b_n_s) |=> !flag_b_q;
  endproperty
  a_edge_b_only: assert property (p_edge_b_only) else $error("Edge flag b set without edge.");

  property p_call_len;
    disable iff (local_rst) $rose(seq_q == SQ_CALL) && cfg_q == '0 |-> ##32 ISR_ENTER_OUT;
  endproperty
  a_call_len: assert property (p_call_len) else $error("Call never completes.");

  property p_enter_count;
    ISR_ENTER_OUT |-> $past(call_cnt_q) == 3'h3;
  endproperty
  a_enter_count: assert property (p_enter_count) else $error("Entry before four call cycles.");

  property p_block;
    block_q && !INSN_DONE_IN |=> seq_q != SQ_CALL || $past(seq_q) == SQ_CALL;
  endproperty
  a_block: assert property (p_block) else $error("Re-entry before a main instruction.");

  property p_rst_hold;
    !por_n_s |-> ##2 CORE_RST_OUT;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("Core left reset with a source active.");

  property p_short_rst;
    $rose(ext_rst_q) |-> $past(!ext_rst_n_s, 8);
  endproperty
  a_short_rst: assert property (p_short_rst) else $error("Short reset pulse accepted.");

  property p_readback;
    SFR_IN.rd && SFR_IN.addr == CLKDIV_ADDR |=> SFR_RDATA_OUT[7:4] == 4'h0;
  endproperty
  a_readback: assert property (p_readback) else $error("Unused divider bits not zero.");

  property p_vector;
    $fell(CORE_RST_OUT) |-> FETCH_ADDR_OUT == RESET_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("Restart address not zero.");

  c_enter:  cover property (ISR_ENTER_OUT);
  c_return: cover property (seq_q == SQ_ISR && RETURN_IN);
  c_fast:   cover property (fast_req && cfg_q.sel == DIV_STOP);
  c_extrst: cover property ($rose(ext_rst_q));
endmodule // irc_sysctl
`default_nettype wire

// >>> testbench/irc_src_model.sv
// Model of the interrupt pins and the core handshake facing the system-control block.
`timescale 1ns/10ps
`default_nettype none
module irc_src_model (
  input  wire logic       clk_in,      // External clock.
  input  wire logic [2:0] fire_in,     // Start a pulse on pin a, b or c.
  input  wire logic       lvl_b_in,    // Hold pin b active.
  input  wire logic       core_en_in,  // Core accepts calls.
  input  wire logic       enter_in,    // Service routine entered.
  input  wire logic [7:0] insn_dly_in, // Cycles from return to next instruction.
  output logic            a_n_out,     // Pin a.
  output logic            b_n_out,     // Pin b.
  output logic            c_out,       // Pin c.
  output logic            bound_out,   // Call boundary.
  output logic            ret_out,     // Return done.
  output logic            done_out     // Main instruction done.
);
  int hold [3];
  int rc;
  int ic;
  initial begin
    hold = '{0, 0, 0};
    rc = 0;
    ic = 0;
    ret_out = 1'b0;
    done_out = 1'b0;
  end
  // Pulses last three sample periods at full speed, so the full-speed sample point cannot miss them.
  always @(posedge clk_in) begin
    for (int i = 0; i < 3; i++) begin
      hold[i] <= fire_in[i] ? 24 : (hold[i] > 0 ? hold[i] - 1 : 0);
    end
  end
  assign a_n_out = !(hold[0] > 0);
  // A level request stays until the bench withdraws it after service.
  assign b_n_out = !(hold[1] > 0 || lvl_b_in);
  assign c_out = hold[2] > 0;
  assign bound_out = core_en_in;
  always @(posedge clk_in) begin
    ret_out <= 1'b0;
    done_out <= 1'b0;
    if (enter_in) begin
      rc <= 10;
    end else if (rc > 1) begin
      rc <= rc - 1;
    end else if (rc == 1) begin
      rc <= 0;
      ret_out <= 1'b1;
      ic <= int'(insn_dly_in);
    end else if (ic > 1) begin
      ic <= ic - 1;
    end else if (ic == 1) begin
      ic <= 0;
      done_out <= 1'b1;
    end
  end
endmodule // irc_src_model
`default_nettype wire

// >>> testbench/irc_sysctl_tb.sv
// Self-checking bench for the system-control block.
`timescale 1ns/10ps
`default_nettype none
module irc_sysctl_tb;
  import irc_pkg::*;
  localparam int PH = 20;
  logic mclk, rst, por_n, ext_n, adc, per_n, tsel, bound, ret, done, lvl_b, core_en, a_n, b_n, c;
  logic fa, fb, fc, enter, crst, lclk, tick;
  logic [2:0] clr, fire;
  logic [3:0] pflags;
  logic [7:0] idly, rdata, mon;
  logic [15:0] fetch;
  irc_sfr_t special_function_reg;
  int n_fail, total_checks;
  assign mon = {enter, ret, done, tick, fa, fb, fc, crst};

  irc_sysctl #(.POR_HOLD(PH), .N_PERIPH(4)) irc_sysctl_i (
    .MCLK_IN(mclk), .RST_IN(rst), .POR_N_IN(por_n), .EXT_RST_N_IN(ext_n),
    .EXT_IRQ_A_N_IN(a_n), .EXT_IRQ_B_N_IN(b_n), .EXT_IRQ_C_IN(c), .PERIPH_IRQ_N_IN(per_n),
    .ADC_IRQ_IN(adc), .PERIPH_FLAGS_IN(pflags), .IRQ_B_TYPE_SEL_IN(tsel),
    .IRQ_A_CLR_IN(clr[0]), .IRQ_B_CLR_IN(clr[1]), .IRQ_C_CLR_IN(clr[2]),
    .CORE_BOUNDARY_IN(bound), .RETURN_IN(ret), .INSN_DONE_IN(done), .SFR_IN(special_function_reg),
    .SFR_RDATA_OUT(rdata), .IRQ_A_FLAG_OUT(fa), .IRQ_B_FLAG_OUT(fb), .IRQ_C_FLAG_OUT(fc),
    .ISR_ENTER_OUT(enter), .CORE_RST_OUT(crst), .FETCH_ADDR_OUT(fetch),
    .LOGIC_CLK_OUT(lclk), .LOGIC_TICK_OUT(tick));

  irc_src_model irc_src_model_i (
    .clk_in(mclk), .fire_in(fire), .lvl_b_in(lvl_b), .core_en_in(core_en), .enter_in(enter),
    .insn_dly_in(idly), .a_n_out(a_n), .b_n_out(b_n), .c_out(c), .bound_out(bound),
    .ret_out(ret), .done_out(done));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [15:0] exp_rd(input logic [7:0] d);
    return {12'h000, d[3:0]};
  endfunction
  function automatic logic [15:0] exp_per(input logic [2:0] s);
    return 16'h0002 << s;
  endfunction

  task automatic cyc(input int k = 1);
    repeat (k) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_v({15'h0000, got}, {15'h0000, exp});
  endtask
  // Every wait is bounded; running out ends the run as a failure.
  task automatic wt(input int b, input logic v, input int lim, output int k);
    k = 0;
    while (mon[b] !== v) begin
      cyc();
      k++;
      if (k > lim) begin
        chk_b(mon[b], v);
        conclude();
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    special_function_reg = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    cyc();
    special_function_reg = '0;
    cyc();
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    special_function_reg = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    cyc();
    d = {8'h00, rdata};
    special_function_reg = '0;
    cyc();
  endtask
  task automatic per(output int p);
    wt(4, 1'b1, 600, p);
    cyc();
    wt(4, 1'b1, 600, p);
    p++;
  endtask
  task automatic pulse(input int i, input logic is_clr);
    if (is_clr) clr[i] = 1'b1;
    else fire[i] = 1'b1;
    cyc();
    clr = 3'h0;
    fire = 3'h0;
  endtask

  initial begin
    logic [7:0] w, a;
    logic [15:0] v;
    int n, k;
    {rst, por_n, ext_n, adc, per_n, tsel, lvl_b, core_en} = 8'hE8;
    {clr, fire, special_function_reg} = '0;
    idly = 8'h50;
    n_fail = 0;
    total_checks = 0;
    void'($urandom(88109));
    pflags = 4'h0;
    cyc(16);
    rst = 1'b0;
    wt(0, 1'b0, 100, n);
    chk_v(fetch, RESET_VECTOR);
    rd(CLKDIV_ADDR, v);
    chk_v(v, {8'h00, CLKDIV_RESET});
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      w = 8'($urandom());
      a = 8'($urandom());
      if (a == CLKDIV_ADDR) a = 8'h00;
      wr(CLKDIV_ADDR, w);
      rd(CLKDIV_ADDR, v);
      chk_v(v, exp_rd(w));
      wr(a, ~w);
      rd(CLKDIV_ADDR, v);
      chk_v(v, exp_rd(w));
      rd(a, v);
      chk_v(v, 16'h0000);
    end
    $display("test register done");
    for (int s = 0; s < 7; s++) begin
      wr(CLKDIV_ADDR, {4'h0, 3'(s), 1'b0});
      per(n);
      per(n);
      chk_v(16'(n), exp_per(3'(s)));
      chk_b(lclk, 1'b1);
    end
    wr(CLKDIV_ADDR, {4'h0, DIV_STOP, 1'b0});
    cyc(300);
    k = 0;
    repeat (300) begin
      cyc();
      if (tick !== 1'b0) k++;
    end
    chk_v(16'(k), 16'h0000);
    chk_b(lclk, 1'b0);
    for (int src = 0; src < 2; src++) begin
      wr(CLKDIV_ADDR, {4'h0, 3'h6, 1'b1});
      per(n);
      per(n);
      chk_v(16'(n), exp_per(3'h6));
      if (src == 0) adc = 1'b1;
      else per_n = 1'b0;
      per(n);
      per(n);
      chk_v(16'(n), exp_per(DIV_FASTEST));
      adc = 1'b0;
      per_n = 1'b1;
    end
    wr(CLKDIV_ADDR, 8'h00);
    per(n);
    $display("test divider done");
    for (int i = 0; i < 3; i += 2) begin
      pulse(i, 1'b0);
      wt(3 - i, 1'b1, 80, n);
      pulse(i, 1'b1);
      cyc(60);
      chk_b(mon[3 - i], 1'b0);
    end
    lvl_b = 1'b1;
    wt(2, 1'b1, 80, n);
    lvl_b = 1'b0;
    cyc(40);
    chk_b(fb, 1'b0);
    lvl_b = 1'b1;
    cyc(40);
    tsel = 1'b1;
    pulse(1, 1'b1);
    cyc(40);
    chk_b(fb, 1'b0);
    lvl_b = 1'b0;
    cyc(20);
    lvl_b = 1'b1;
    wt(2, 1'b1, 80, n);
    lvl_b = 1'b0;
    pulse(1, 1'b1);
    $display("test sampling done");
    core_en = 1'b1;
    pulse(0, 1'b0);
    wt(3, 1'b1, 80, n);
    wt(7, 1'b1, 60, n);
    chk_v(16'(n), 16'(MIN_LATENCY * PHASES_PER_INSN) * exp_per(DIV_FASTEST) - 16'h0001);
    pulse(0, 1'b1);
    cyc(150);
    tsel = 1'b0;
    lvl_b = 1'b1;
    wt(7, 1'b1, 80, n);
    wt(6, 1'b1, 40, n);
    wt(7, 1'b1, 250, n);
    chk_b(n > 80, 1'b1);
    lvl_b = 1'b0;
    // Once the level source is gone, only a timer or serial flag can cause the next entry.
    pflags = 4'($urandom_range(15, 1));
    wt(6, 1'b1, 40, n);
    wt(7, 1'b1, 250, n);
    chk_b(mon[7], 1'b1);
    pflags = 4'h0;
    core_en = 1'b0;
    cyc(200);
    $display("test service done");
    ext_n = 1'b0;
    cyc(3);
    ext_n = 1'b1;
    cyc(30);
    chk_b(crst, 1'b0);
    wr(CLKDIV_ADDR, 8'h0B);
    ext_n = 1'b0;
    wt(0, 1'b1, 30, n);
    cyc(20);
    chk_b(crst, 1'b1);
    ext_n = 1'b1;
    wt(0, 1'b0, 100, n);
    rd(CLKDIV_ADDR, v);
    chk_v(v, {8'h00, CLKDIV_RESET});
    por_n = 1'b0;
    wt(0, 1'b1, 20, n);
    por_n = 1'b1;
    wt(0, 1'b0, 100, n);
    chk_b(n >= PH, 1'b1);
    $display("test reset sources done");
    conclude();
  end
endmodule // irc_sysctl_tb
`default_nettype wire
